// ---- inc/prm_defines.vh ----
// Constants for the processor register model.
//
// Contract
// - 32 general registers, 12 hidden rename buffers
// - 32 float registers, 64-bit, eight rename buffers
// - Condition fields, eight nibbles, eight rename buffers
// - Privilege bit in machine state selects rights
// - Privileged operations execute only in supervisor
// - Machine state saved on exception, restored
// - Sixteen 32-bit segment registers
// - Special registers 32-bit, move-to/from accessible
// - Link register captures branch-and-link return
// - Loop counter decrements on branch-and-count
// - Fixed-point exception register holds carry, overflow
// - Time base user-readable, supervisor-writable only
// - 64-bit time base counts at quarter clock
// - Decrementer counts down, raises exception
// - Save address records faulting instruction, resume
// - Save status captures and restores machine status
// - Data fault address loaded on data faults
// - Data fault cause recorded on data faults
// - Version register read-only, writes ignored
// - Processor tag in low four bits
// - Breakpoint on instruction or data address match
`ifndef PRM_DEFINES_VH
`define PRM_DEFINES_VH

// Special register numbers used by move-to and move-from.
`define PRM_SPR_XER 10'h001
`define PRM_SPR_LINK 10'h002
`define PRM_SPR_LOOP 10'h003
`define PRM_SPR_TBL 10'h004
`define PRM_SPR_TBH 10'h005
`define PRM_SPR_DEC 10'h006
`define PRM_SPR_SAVE_ADDR 10'h007
`define PRM_SPR_SAVE_STAT 10'h008
`define PRM_SPR_FLT_ADDR 10'h009
`define PRM_SPR_FLT_CAUSE 10'h00a
`define PRM_SPR_VERSION 10'h00b
`define PRM_SPR_TAG 10'h00c
`define PRM_SPR_IBRK 10'h00d
`define PRM_SPR_DBRK 10'h00e

// Field positions.
`define PRM_MSR_PRIV_BIT 14
`define PRM_XER_OV_BIT 30
`define PRM_XER_CA_BIT 29
`define PRM_BRK_EN_BIT 0
`define PRM_TAG_W 4

// Reset values and timing.
`define PRM_MSR_RST 32'h0000_0000
`define PRM_TICK_DIV 2'h3
`endif

// ---- rtl/prm_timer.v ----
// Time base and decrementer counting at a quarter of the clock.
`timescale 1ns/1ps
`default_nettype none
module prm_timer (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_tb_en,
  input wire i_tbl_wr,
  input wire i_tbh_wr,
  input wire i_dec_wr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_tbl,
  output reg [31:0] o_tbh,
  output reg [31:0] o_dec,
  output reg o_dec_exc
);
`include "prm_defines.vh"

  reg [1:0] div_q;
  wire tick;

  ////////////////////////////////////////////////////////////////////////
  // quarter rate enable
  assign tick = (div_q == `PRM_TICK_DIV);

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      div_q <= 2'h0;
      o_tbl <= 32'h0000_0000;
      o_tbh <= 32'h0000_0000;
      o_dec <= 32'h0000_0000;
      o_dec_exc <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      o_dec_exc <= 1'b0;
      if (i_tbl_wr) begin
        o_tbl <= i_wdata;
      end else if (tick && i_tb_en) begin
        o_tbl <= o_tbl + 32'h0000_0001;
      end
      if (i_tbh_wr) begin
        o_tbh <= i_wdata;
      end else if (tick && i_tb_en && !i_tbl_wr && (o_tbl == 32'hffff_ffff)) begin
        o_tbh <= o_tbh + 32'h0000_0001;
      end
      if (i_dec_wr) begin
        o_dec <= i_wdata;
      end else if (tick) begin
        o_dec <= o_dec - 32'h0000_0001;
        if (o_dec == 32'h0000_0000) begin
          o_dec_exc <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/prm_core.v ----
// Architected register set with privilege control and special registers.
`timescale 1ns/1ps
`default_nettype none
module prm_core #(
  parameter GPR_REN = 12,
  parameter FPR_REN = 8,
  parameter CR_REN = 8,
  parameter [31:0] VERSION = 32'h0001_0001
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_tb_en_pin,
  input wire i_gpr_ren_wr,
  input wire [3:0] i_gpr_ren_idx,
  input wire [4:0] i_gpr_ren_dst,
  input wire [31:0] i_gpr_ren_data,
  input wire i_gpr_commit,
  input wire [3:0] i_gpr_commit_idx,
  input wire [4:0] i_gpr_raddr,
  output reg [31:0] o_gpr_rdata,
  input wire i_fpr_ren_wr,
  input wire [2:0] i_fpr_ren_idx,
  input wire [4:0] i_fpr_ren_dst,
  input wire [63:0] i_fpr_ren_data,
  input wire i_fpr_commit,
  input wire [2:0] i_fpr_commit_idx,
  input wire [4:0] i_fpr_raddr,
  output reg [63:0] o_fpr_rdata,
  input wire i_cr_ren_wr,
  input wire [2:0] i_cr_ren_idx,
  input wire [2:0] i_cr_ren_field,
  input wire [3:0] i_cr_ren_data,
  input wire i_cr_commit,
  input wire [2:0] i_cr_commit_idx,
  output reg [31:0] o_condition_fields,
  input wire i_msr_wr,
  input wire [31:0] i_msr_wdata,
  output reg [31:0] o_msr,
  output reg o_supervisor,
  input wire i_priv_op,
  output reg o_priv_fault,
  input wire i_sr_wr,
  input wire [3:0] i_sr_idx,
  input wire [31:0] i_sr_wdata,
  output reg [31:0] o_sr_rdata,
  input wire i_spr_wr,
  input wire i_spr_rd,
  input wire [9:0] i_spr_num,
  input wire [31:0] i_spr_wdata,
  output reg [31:0] o_spr_rdata,
  output reg o_spr_ack,
  input wire i_bl,
  input wire [31:0] i_bl_ret,
  output reg [31:0] o_link,
  input wire i_bc,
  output reg o_loop_zero,
  input wire i_xer_upd,
  input wire i_ca,
  input wire i_ov,
  input wire i_exc_take,
  input wire [31:0] i_exc_pc,
  input wire i_dfault,
  input wire [31:0] i_dfault_addr,
  input wire [31:0] i_dfault_cause,
  input wire i_rfi,
  output reg o_resume,
  output reg [31:0] o_resume_pc,
  input wire i_fetch_vld,
  input wire [31:0] i_fetch_addr,
  input wire i_data_vld,
  input wire [31:0] i_data_addr,
  output reg o_brk_exc,
  output reg o_dec_exc
);
`include "prm_defines.vh"

  reg [31:0] general_register [0:31];
  reg [31:0] gren_data [0:GPR_REN-1];
  reg [4:0] gren_dst [0:GPR_REN-1];
  reg [63:0] float_register [0:31];
  reg [63:0] fren_data [0:FPR_REN-1];
  reg [4:0] fren_dst [0:FPR_REN-1];
  reg [3:0] cren_data [0:CR_REN-1];
  reg [2:0] cren_fld [0:CR_REN-1];
  reg [31:0] seg [0:15];
  reg [31:0] xer_q;
  reg [31:0] loop_q;
  reg [31:0] save_addr_q;
  reg [31:0] save_stat_q;
  reg [31:0] flt_addr_q;
  reg [31:0] flt_cause_q;
  reg [3:0] tag_q;
  reg [31:0] ibrk_q;
  reg [31:0] dbrk_q;
  reg tbe_meta_q;
  reg tbe_q;
  reg sup_spr;
  reg known_spr;
  reg [31:0] rd_d;
  wire [31:0] time_base_low;
  wire [31:0] tbh;
  wire [31:0] dec;
  wire dec_exc;
  wire sup;
  wire spr_ok;
  wire wr_ok;
  wire [31:0] loop_next;
  integer k;
  integer j;

  ////////////////////////////////////////////////////////////////////////
  // privilege from machine state
  assign sup = ~o_msr[`PRM_MSR_PRIV_BIT];
  assign spr_ok = known_spr && (sup || !sup_spr);
  assign wr_ok = i_spr_wr && spr_ok && (i_spr_num != `PRM_SPR_VERSION);
  assign loop_next = loop_q - 32'h0000_0001;

  always @* begin
    known_spr = 1'b1;
    sup_spr = 1'b1;
    rd_d = 32'h0000_0000;
    if (i_spr_num == `PRM_SPR_XER) begin
      sup_spr = 1'b0;
      rd_d = xer_q;
    end else if (i_spr_num == `PRM_SPR_LINK) begin
      sup_spr = 1'b0;
      rd_d = o_link;
    end else if (i_spr_num == `PRM_SPR_LOOP) begin
      sup_spr = 1'b0;
      rd_d = loop_q;
    end else if (i_spr_num == `PRM_SPR_TBL) begin
      sup_spr = i_spr_wr;
      rd_d = time_base_low;
    end else if (i_spr_num == `PRM_SPR_TBH) begin
      sup_spr = i_spr_wr;
      rd_d = tbh;
    end else if (i_spr_num == `PRM_SPR_DEC) begin
      rd_d = dec;
    end else if (i_spr_num == `PRM_SPR_SAVE_ADDR) begin
      rd_d = save_addr_q;
    end else if (i_spr_num == `PRM_SPR_SAVE_STAT) begin
      rd_d = save_stat_q;
    end else if (i_spr_num == `PRM_SPR_FLT_ADDR) begin
      rd_d = flt_addr_q;
    end else if (i_spr_num == `PRM_SPR_FLT_CAUSE) begin
      rd_d = flt_cause_q;
    end else if (i_spr_num == `PRM_SPR_VERSION) begin
      rd_d = VERSION;
    end else if (i_spr_num == `PRM_SPR_TAG) begin
      rd_d = {28'h000_0000, tag_q};
    end else if (i_spr_num == `PRM_SPR_IBRK) begin
      rd_d = ibrk_q;
    end else if (i_spr_num == `PRM_SPR_DBRK) begin
      rd_d = dbrk_q;
    end else begin
      known_spr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable pin synchroniser.
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      tbe_meta_q <= 1'b0;
      tbe_q <= 1'b0;
    end else begin
      tbe_meta_q <= i_tb_en_pin;
      tbe_q <= tbe_meta_q;
    end
  end

  prm_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_tb_en(tbe_q),
    .i_tbl_wr(wr_ok && (i_spr_num == `PRM_SPR_TBL)),
    .i_tbh_wr(wr_ok && (i_spr_num == `PRM_SPR_TBH)),
    .i_dec_wr(wr_ok && (i_spr_num == `PRM_SPR_DEC)),
    .i_wdata(i_spr_wdata),
    .o_tbl(time_base_low),
    .o_tbh(tbh),
    .o_dec(dec),
    .o_dec_exc(dec_exc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register files and rename buffers.
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (k = 0; k < 32; k = k + 1) begin
        general_register[k] <= 32'h0000_0000;
        float_register[k] <= 64'h0000_0000_0000_0000;
      end
      o_condition_fields <= 32'h0000_0000;
      o_gpr_rdata <= 32'h0000_0000;
      o_fpr_rdata <= 64'h0000_0000_0000_0000;
    end else begin
      o_gpr_rdata <= general_register[i_gpr_raddr];
      o_fpr_rdata <= float_register[i_fpr_raddr];
      if (i_gpr_commit) begin
        general_register[gren_dst[i_gpr_commit_idx]] <= gren_data[i_gpr_commit_idx];
      end
      if (i_fpr_commit) begin
        float_register[fren_dst[i_fpr_commit_idx]] <= fren_data[i_fpr_commit_idx];
      end
      if (i_cr_commit) begin
        o_condition_fields[cren_fld[i_cr_commit_idx]*4 +: 4] <= cren_data[i_cr_commit_idx];
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_gpr_ren_wr) begin
      gren_data[i_gpr_ren_idx] <= i_gpr_ren_data;
      gren_dst[i_gpr_ren_idx] <= i_gpr_ren_dst;
    end
    if (i_fpr_ren_wr) begin
      fren_data[i_fpr_ren_idx] <= i_fpr_ren_data;
      fren_dst[i_fpr_ren_idx] <= i_fpr_ren_dst;
    end
    if (i_cr_ren_wr) begin
      cren_data[i_cr_ren_idx] <= i_cr_ren_data;
      cren_fld[i_cr_ren_idx] <= i_cr_ren_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Segment registers, written only in supervisor mode.
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (j = 0; j < 16; j = j + 1) begin
        seg[j] <= 32'h0000_0000;
      end
      o_sr_rdata <= 32'h0000_0000;
    end else begin
      o_sr_rdata <= seg[i_sr_idx];
      if (i_sr_wr && sup) begin
        seg[i_sr_idx] <= i_sr_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Machine state, exceptions and special registers.
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_msr <= `PRM_MSR_RST;
      o_supervisor <= 1'b1;
      o_priv_fault <= 1'b0;
      o_spr_rdata <= 32'h0000_0000;
      o_spr_ack <= 1'b0;
      o_link <= 32'h0000_0000;
      o_loop_zero <= 1'b0;
      o_resume <= 1'b0;
      o_resume_pc <= 32'h0000_0000;
      o_brk_exc <= 1'b0;
      o_dec_exc <= 1'b0;
      xer_q <= 32'h0000_0000;
      loop_q <= 32'h0000_0000;
      save_addr_q <= 32'h0000_0000;
      save_stat_q <= 32'h0000_0000;
      flt_addr_q <= 32'h0000_0000;
      flt_cause_q <= 32'h0000_0000;
      tag_q <= 4'h0;
      ibrk_q <= 32'h0000_0000;
      dbrk_q <= 32'h0000_0000;
    end else begin
      o_supervisor <= sup;
      o_dec_exc <= dec_exc;
      o_resume <= 1'b0;
      o_spr_ack <= i_spr_rd || i_spr_wr;
      if (i_spr_rd && spr_ok) begin
        o_spr_rdata <= rd_d;
      end else if (i_spr_rd) begin
        o_spr_rdata <= 32'h0000_0000;
      end
      o_priv_fault <= ((i_spr_rd || i_spr_wr) && !spr_ok) || ((i_priv_op || i_msr_wr) && !sup);
      if (wr_ok) begin
        if (i_spr_num == `PRM_SPR_XER) begin
          xer_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_SAVE_ADDR) begin
          save_addr_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_SAVE_STAT) begin
          save_stat_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_FLT_ADDR) begin
          flt_addr_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_FLT_CAUSE) begin
          flt_cause_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_TAG) begin
          tag_q <= i_spr_wdata[`PRM_TAG_W-1:0];
        end else if (i_spr_num == `PRM_SPR_IBRK) begin
          ibrk_q <= i_spr_wdata;
        end else if (i_spr_num == `PRM_SPR_DBRK) begin
          dbrk_q <= i_spr_wdata;
        end
      end
      if (i_bl) begin
        o_link <= i_bl_ret;
      end else if (wr_ok && (i_spr_num == `PRM_SPR_LINK)) begin
        o_link <= i_spr_wdata;
      end
      o_loop_zero <= 1'b0;
      if (i_bc) begin
        loop_q <= loop_next;
        o_loop_zero <= (loop_next == 32'h0000_0000);
      end else if (wr_ok && (i_spr_num == `PRM_SPR_LOOP)) begin
        loop_q <= i_spr_wdata;
      end
      if (i_xer_upd) begin
        xer_q[`PRM_XER_CA_BIT] <= i_ca;
        xer_q[`PRM_XER_OV_BIT] <= i_ov;
      end
      if (i_dfault) begin
        flt_addr_q <= i_dfault_addr;
        flt_cause_q <= i_dfault_cause;
      end
      if (i_exc_take) begin
        save_addr_q <= i_exc_pc;
        save_stat_q <= o_msr;
        o_msr[`PRM_MSR_PRIV_BIT] <= 1'b0;
      end else if (i_rfi && sup) begin
        o_msr <= save_stat_q;
        o_resume <= 1'b1;
        o_resume_pc <= save_addr_q;
      end else if (i_msr_wr && sup) begin
        o_msr <= i_msr_wdata;
      end
      o_brk_exc <= (i_fetch_vld && ibrk_q[`PRM_BRK_EN_BIT] && (ibrk_q[31:2] == i_fetch_addr[31:2]))
        || (i_data_vld && dbrk_q[`PRM_BRK_EN_BIT] && (dbrk_q[31:2] == i_data_addr[31:2]));
    end
  end
endmodule
`default_nettype wire

// ---- tb/prm_props.sv ----
// Port checker for the processor register model.
`timescale 1ns/1ps
`default_nettype none
module prm_props (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_spr_rd,
  input wire logic i_spr_wr,
  input wire logic i_priv_op,
  input wire logic i_msr_wr,
  input wire logic i_rfi,
  input wire logic i_exc_take,
  input wire logic i_bl,
  input wire logic [31:0] i_bl_ret,
  input wire logic i_fetch_vld,
  input wire logic i_data_vld,
  input wire logic i_bc,
  input wire logic o_spr_ack,
  input wire logic o_priv_fault,
  input wire logic o_resume,
  input wire logic o_brk_exc,
  input wire logic o_loop_zero,
  input wire logic [31:0] o_msr,
  input wire logic [31:0] o_link
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_spr_req;
    i_spr_rd || i_spr_wr;
  endsequence
  sequence s_user_op;
    o_msr[14] && $past(o_msr[14]) && i_priv_op;
  endsequence
  sequence s_super_op;
    !o_msr[14] && !$past(o_msr[14]) && (i_priv_op || i_msr_wr) && !i_spr_rd && !i_spr_wr;
  endsequence
  sequence s_super_rfi;
    !o_msr[14] && !$past(o_msr[14]) && i_rfi && !i_exc_take;
  endsequence
  a_spr_ack_timing: assert property (s_spr_req |=> o_spr_ack)
    else $error("special register access not acknowledged");
  a_spr_ack_cause: assert property (o_spr_ack |-> $past(i_spr_rd || i_spr_wr))
    else $error("acknowledge without access");
  a_user_op_fault: assert property (s_user_op |=> o_priv_fault)
    else $error("privileged operation in user mode not refused");
  a_super_op_ok: assert property (s_super_op |=> !o_priv_fault)
    else $error("supervisor operation refused");
  a_exc_enters_super: assert property (i_exc_take |=> !o_msr[14])
    else $error("exception did not enter supervisor");
  a_rfi_resumes: assert property (s_super_rfi |=> o_resume)
    else $error("return from interrupt did not resume");
  a_link_capture: assert property (i_bl |=> o_link == $past(i_bl_ret))
    else $error("link register missed return address");
  a_brk_cause: assert property (o_brk_exc |-> $past(i_fetch_vld || i_data_vld))
    else $error("breakpoint without access");
  a_loop_zero_cause: assert property (o_loop_zero |-> $past(i_bc))
    else $error("loop zero without branch and count");
endmodule
bind prm_core prm_props prm_props_i (.*);
`default_nettype wire

// ---- tb/processor_register_model_tb.sv ----
// Testbench for the processor register model.
`timescale 1ns/1ps
`default_nettype none
`include "prm_defines.vh"
module processor_register_model_tb;
  // Arbitrary version value.
  localparam logic [31:0] VER = 32'h0001_0001;
  logic i_ref_clk = 0, i_reset = 1, i_tb_en_pin = 0, i_gpr_ren_wr = 0, i_gpr_commit = 0, i_fpr_ren_wr = 0;
  logic i_fpr_commit = 0, i_cr_ren_wr = 0, i_cr_commit = 0, i_msr_wr = 0, i_priv_op = 0, i_sr_wr = 0;
  logic i_spr_wr = 0, i_spr_rd = 0, i_bl = 0, i_bc = 0, i_xer_upd = 0, i_ca = 0, i_ov = 0, i_exc_take = 0;
  logic i_dfault = 0, i_rfi = 0, i_fetch_vld = 0, i_data_vld = 0;
  logic [3:0] i_gpr_ren_idx = 0, i_gpr_commit_idx = 0, i_sr_idx = 0, i_cr_ren_data = 0;
  logic [4:0] i_gpr_ren_dst = 0, i_gpr_raddr = 0, i_fpr_ren_dst = 0, i_fpr_raddr = 0;
  logic [2:0] i_fpr_ren_idx = 0, i_fpr_commit_idx = 0, i_cr_ren_idx = 0, i_cr_ren_field = 0, i_cr_commit_idx = 0;
  logic [9:0] i_spr_num = 0;
  logic [31:0] i_gpr_ren_data = 0, i_msr_wdata = 0, i_sr_wdata = 0, i_spr_wdata = 0, i_bl_ret = 0;
  logic [31:0] i_exc_pc = 0, i_dfault_addr = 0, i_dfault_cause = 0, i_fetch_addr = 0, i_data_addr = 0;
  logic [63:0] i_fpr_ren_data = 0;
  wire [31:0] o_gpr_rdata, o_condition_fields, o_msr, o_sr_rdata, o_spr_rdata, o_link, o_resume_pc;
  wire [63:0] o_fpr_rdata;
  wire o_supervisor, o_priv_fault, o_spr_ack, o_loop_zero, o_resume, o_brk_exc, o_dec_exc;
  int errors = 0, n_tests = 0, n;
  logic [31:0] rd;
  logic ack, flt;
  logic [3:0] snap;
  prm_core #(.VERSION(VER)) prm_core_i (.*);
  always #5 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic special_register(input logic w, input logic [9:0] num, input logic [31:0] d);
    i_spr_wr = w;
    i_spr_rd = !w;
    i_spr_num = num;
    i_spr_wdata = d;
    tick;
    ack = o_spr_ack;
    flt = o_priv_fault;
    rd = o_spr_rdata;
    i_spr_wr = 0;
    i_spr_rd = 0;
    tick;
  endtask
  // Pulses a command for one cycle and snapshots the one-cycle answers.
  task automatic pulse(ref logic s);
    s = 1;
    tick;
    s = 0;
    snap = {o_priv_fault, o_loop_zero, o_resume, o_brk_exc};
    tick;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1 i_reset = 0;
    chk("reset_mode", {o_supervisor, o_msr}, {1'b1, 32'h0000_0000});
    special_register(1, `PRM_SPR_LINK, 32'h1234_5678);
    special_register(0, `PRM_SPR_LINK, 32'h0000_0000);
    chk("link_rd", {ack, flt, rd}, {2'h2, 32'h1234_5678});
    i_bl_ret = 32'h0000_2004;
    pulse(i_bl);
    chk("link_bl", o_link, 32'h0000_2004);
    special_register(1, `PRM_SPR_LOOP, 32'h0000_0002);
    pulse(i_bc);
    chk("loop_one", snap[2], 1'h0);
    pulse(i_bc);
    chk("loop_zero", snap[2], 1'h1);
    special_register(1, `PRM_SPR_VERSION, 32'hffff_ffff);
    special_register(0, `PRM_SPR_VERSION, 32'h0000_0000);
    chk("version", rd, VER);
    special_register(1, `PRM_SPR_TAG, 32'hffff_ffff);
    special_register(0, `PRM_SPR_TAG, 32'h0000_0000);
    chk("tag", rd, 32'h0000_000f);
    i_ca = 1;
    i_ov = 1;
    pulse(i_xer_upd);
    special_register(0, `PRM_SPR_XER, 32'h0000_0000);
    chk("xer", rd, 32'h6000_0000);
    i_dfault_addr = 32'h0000_3003;
    i_dfault_cause = 32'h0400_0000;
    pulse(i_dfault);
    special_register(0, `PRM_SPR_FLT_ADDR, 32'h0000_0000);
    chk("flt_addr", rd, 32'h0000_3003);
    special_register(0, `PRM_SPR_FLT_CAUSE, 32'h0000_0000);
    chk("flt_cause", rd, 32'h0400_0000);
    i_gpr_ren_idx = 4'hb;
    i_gpr_ren_dst = 5'h1f;
    i_gpr_ren_data = 32'ha5a5_0001;
    pulse(i_gpr_ren_wr);
    i_gpr_commit_idx = 4'hb;
    i_gpr_raddr = 5'h1f;
    pulse(i_gpr_commit);
    chk("gpr", o_gpr_rdata, 32'ha5a5_0001);
    i_fpr_ren_idx = 3'h7;
    i_fpr_ren_data = 64'h0123_4567_89ab_cdef;
    pulse(i_fpr_ren_wr);
    i_fpr_commit_idx = 3'h7;
    pulse(i_fpr_commit);
    chk("fpr", o_fpr_rdata, 64'h0123_4567_89ab_cdef);
    i_cr_ren_idx = 3'h7;
    i_cr_ren_field = 3'h7;
    i_cr_ren_data = 4'ha;
    pulse(i_cr_ren_wr);
    i_cr_commit_idx = 3'h7;
    pulse(i_cr_commit);
    chk("cr", o_condition_fields, 32'ha000_0000);
    i_sr_idx = 4'hf;
    i_sr_wdata = 32'h5a5a_000f;
    pulse(i_sr_wr);
    chk("sr", o_sr_rdata, 32'h5a5a_000f);
    special_register(1, `PRM_SPR_IBRK, 32'h0000_1001);
    special_register(1, `PRM_SPR_DBRK, 32'h0000_2001);
    i_fetch_addr = 32'h0000_1004;
    pulse(i_fetch_vld);
    chk("brk_miss", snap[0], 1'h0);
    i_fetch_addr = 32'h0000_1000;
    pulse(i_fetch_vld);
    chk("brk_fetch", snap[0], 1'h1);
    i_data_addr = 32'h0000_2002;
    pulse(i_data_vld);
    chk("brk_data", snap[0], 1'h1);
    i_tb_en_pin = 1;
    special_register(1, `PRM_SPR_TBH, 32'h0000_0000);
    special_register(1, `PRM_SPR_TBL, 32'hffff_fffe);
    repeat (16) tick;
    special_register(0, `PRM_SPR_TBH, 32'h0000_0000);
    chk("tb_carry", rd, 32'h0000_0001);
    special_register(1, `PRM_SPR_TBL, 32'h0000_0000);
    repeat (40) tick;
    special_register(0, `PRM_SPR_TBL, 32'h0000_0000);
    chk("tb_rate", rd >= 10 && rd <= 11, 1'h1);
    i_tb_en_pin = 0;
    repeat (4) tick;
    special_register(1, `PRM_SPR_TBL, 32'h0000_0005);
    repeat (20) tick;
    special_register(0, `PRM_SPR_TBL, 32'h0000_0000);
    chk("tb_hold", rd, 32'h0000_0005);
    special_register(1, `PRM_SPR_DEC, 32'h0000_0003);
    n = 0;
    while (o_dec_exc !== 1'b1 && n < 60) begin
      tick;
      n++;
    end
    chk("dec_delay", n >= 13 && n <= 16, 1'h1);
    i_msr_wdata = 32'h0000_0030;
    pulse(i_msr_wr);
    i_exc_pc = 32'h0000_0700;
    pulse(i_exc_take);
    special_register(0, `PRM_SPR_SAVE_ADDR, 32'h0000_0000);
    chk("save_addr", rd, 32'h0000_0700);
    special_register(0, `PRM_SPR_SAVE_STAT, 32'h0000_0000);
    chk("save_stat", rd, 32'h0000_0030);
    i_msr_wdata = 32'h0000_4000;
    pulse(i_msr_wr);
    tick;
    chk("user_mode", {o_supervisor, o_msr}, {1'b0, 32'h0000_4000});
    special_register(1, `PRM_SPR_TBL, 32'h0000_0000);
    chk("user_tb_wr", {ack, flt}, 2'h3);
    special_register(0, `PRM_SPR_TBL, 32'h0000_0000);
    chk("user_tb_rd", {ack, flt}, 2'h2);
    special_register(0, `PRM_SPR_DEC, 32'h0000_0000);
    chk("user_dec", {ack, flt, rd}, {2'h3, 32'h0000_0000});
    pulse(i_priv_op);
    chk("user_priv", snap[3], 1'h1);
    i_sr_wdata = 32'h0000_0bad;
    pulse(i_sr_wr);
    chk("user_sr", {snap[3], o_sr_rdata}, {1'b0, 32'h5a5a_000f});
    i_msr_wdata = 32'h0000_0000;
    pulse(i_msr_wr);
    chk("user_msr", {snap[3], o_msr}, {1'b1, 32'h0000_4000});
    i_exc_pc = 32'h0000_0800;
    pulse(i_exc_take);
    chk("exc_super", o_msr[14], 1'h0);
    tick;
    pulse(i_rfi);
    chk("rfi", {snap[1], o_resume_pc, o_msr}, {1'b1, 32'h0000_0800, 32'h0000_4000});
    report_and_stop;
  end
endmodule
`default_nettype wire
